// *** logic/rfs_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfs_dev #(
  parameter int MS_CYC = rfs_pkg::MS_CYC,
  parameter int NFAN   = 2
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // link to host
  rfs_link_if.dev                link,
  // power stage conditions
  input  wire logic              present,
  input  wire logic              vin_present,
  input  wire logic              vin_bad,
  input  wire logic              pgood,
  input  wire logic              fault_ov,
  input  wire logic              fault_ot,
  input  wire logic              fault_prim,
  input  wire logic              in_limit,
  input  wire logic              vout_above_7v,
  input  wire logic              oring_fail,
  input  wire logic [7:0]        info_in,
  input  wire logic [7:0]        warn_in,
  input  wire logic [15:0]       fan_rpm [NFAN],
  input  wire logic [2:0]        addr_strap,
  // fault response configuration
  input  wire logic [2:0]        latch_cfg,
  input  wire logic              nv_latch,
  // outputs
  output logic                   power_en,
  output logic                   cc_hold,
  output logic                   oring_run,
  output logic                   hiccup,
  output logic                   led_out,
  output logic                   led_in,
  output logic                   led_fault,
  output logic                   led_aux,
  output logic                   fault_pin
);
  localparam int W = rfs_pkg::MSW;

  typedef struct packed {
    rfs_pkg::rfs_dev_st_t st;
    logic [31:0]  div;
    logic [W-1:0] tmr;
    logic [W-1:0] off_tmr;
    logic [W-1:0] win_tmr;
    logic [W-1:0] set_tmr;
    logic [W-1:0] led_tmr;
    logic [W-1:0] blk_tmr;
    logic [W-1:0] str_tmr;
    logic         blink;
    logic         win_act;
    logic [1:0]   tries;
    logic [1:0]   cause;
    logic         rs_pend;
    logic         settled;
    logic [2:0]   addr;
    logic [7:0]   test;
    logic         op_on;
    logic         frozen;
    logic [7:0]   status;
    logic [7:0]   status2;
    logic [7:0]   alarm;
    logic [7:0]   info;
    logic         alert_pend;
    logic         ack;
    logic         miss;
    logic [7:0]   rdata;
  } rfs_dev_t;

  rfs_dev_t r;
  rfs_dev_t n;

  function automatic logic [W-1:0] inc(logic [W-1:0] v, logic t);
    return (t && v != '1) ? v + 1'b1 : v;
  endfunction

  function automatic logic [W-1:0] ms(int v);
    return v[W-1:0];
  endfunction

  logic        tick;
  logic        want_on;
  logic        oc_cond;
  logic        lit;
  logic        fan_warn;
  logic [31:0] fmax;
  logic [31:0] fmin;
  logic [3:0]  cfg;
  logic [7:0]  al_live;
  logic [7:0]  inf_live;
  logic        clr;
  logic [2:0]  my_addr;

  // ---------------------------------------------------------------
  // fan spread
  // ---------------------------------------------------------------
  always_comb
  begin
    fmax = 32'h0;
    fmin = 32'hffffffff;
    for (int i = 0; i < NFAN; i++)
    begin
      if ({16'h0, fan_rpm[i]} > fmax) fmax = {16'h0, fan_rpm[i]};
      if ({16'h0, fan_rpm[i]} < fmin) fmin = {16'h0, fan_rpm[i]};
    end
    fan_warn = (NFAN > 1) && ((fmax - fmin) * 32'(rfs_pkg::PCT_FULL) >
               fmax * 32'(rfs_pkg::FAN_PCT));
  end

  assign tick    = (r.div == 32'(MS_CYC - 1));
  assign want_on = link.enable & r.op_on & present & vin_present;
  assign oc_cond = in_limit & ~vout_above_7v;
  assign cfg     = {nv_latch, latch_cfg};
  assign lit     = r.led_tmr < ms(rfs_pkg::LED_ON_MS);
  assign my_addr = r.settled ? r.addr : rfs_pkg::ADDR_DEFAULT;

  always_comb
  begin
    n = r;
    n.ack = 1'b0;
    n.miss = 1'b0;
    clr = 1'b0;
    n.div = tick ? 32'h0 : r.div + 32'h1;
    n.tmr = inc(r.tmr, tick);
    n.win_tmr = inc(r.win_tmr, tick);
    n.str_tmr = inc(r.str_tmr, tick);
    n.blk_tmr = inc(r.blk_tmr, tick);
    if (tick && r.blk_tmr >= ms(rfs_pkg::BLINK_MS - 1))
    begin
      n.blk_tmr = '0;
      n.blink = ~r.blink;
    end
    // 7 s lit, 2 s dark cycle
    n.led_tmr = inc(r.led_tmr, tick);
    if (!r.test[rfs_pkg::TEST_LED] || (tick && r.led_tmr >=
        ms(rfs_pkg::LED_ON_MS + rfs_pkg::LED_OFF_MS - 1)))
      n.led_tmr = '0;
    if (!want_on)
      n.off_tmr = inc(r.off_tmr, tick);
    if (!present)
    begin
      n.set_tmr = '0;
      n.settled = 1'b0;
    end
    else
    begin
      n.set_tmr = inc(r.set_tmr, tick);
      if (!r.settled && r.set_tmr >= ms(rfs_pkg::ADDR_SETTLE_MS))
      begin
        n.settled = 1'b1;
        n.addr = addr_strap;
      end
    end
    if (r.win_act && r.win_tmr >= ms(rfs_pkg::OV_WIN_MS))
    begin
      n.win_act = 1'b0;
      n.tries = 2'h0;
    end

    // -------------------------------------------------------------
    // link access
    // -------------------------------------------------------------
    if (link.req && !r.ack)
    begin
      n.ack = 1'b1;
      n.miss = (link.sel != my_addr);
      n.rdata = 8'h00;
      if (link.sel == my_addr)
      begin
        if (link.wr)
        begin
          case (link.addr)
            rfs_pkg::REG_TEST: n.test = link.wdata & rfs_pkg::TEST_MASK;
            rfs_pkg::REG_OP: n.op_on = link.wdata[rfs_pkg::OP_ON];
            rfs_pkg::REG_CLEAR: clr = 1'b1;
            default: ;
          endcase
        end
        else
        begin
          case (link.addr)
            rfs_pkg::REG_TEST: n.rdata = r.test & rfs_pkg::TEST_MASK;
            rfs_pkg::REG_OP: n.rdata = {r.op_on, 7'h0};
            rfs_pkg::REG_STATUS: n.rdata = r.status;
            rfs_pkg::REG_STATUS2: n.rdata = r.status2;
            rfs_pkg::REG_ALARM: n.rdata = r.alarm;
            rfs_pkg::REG_INFO: n.rdata = r.info;
            default: n.rdata = 8'h00;
          endcase
          if (link.addr == rfs_pkg::REG_STATUS)
            n.alert_pend = 1'b0;
        end
      end
    end

    // -------------------------------------------------------------
    // power state machine
    // -------------------------------------------------------------
    case (r.st)
      rfs_pkg::S_OFF:
      begin
        if (want_on)
        begin
          n.st = rfs_pkg::S_START;
          n.tmr = '0;
        end
      end
      rfs_pkg::S_START, rfs_pkg::S_ON:
      begin
        if (!want_on)
          n.st = rfs_pkg::S_OFF;
        else if (r.st == rfs_pkg::S_START && pgood && !in_limit)
        begin
          n.st = rfs_pkg::S_ON;
          if (r.rs_pend)
          begin
            n.rs_pend = 1'b0;
            n.frozen = 1'b0;
            n.alarm = 8'h00;
            n.info = 8'h00;
            n.status2[rfs_pkg::S2_RESTART_OK] = 1'b1;
          end
        end
        if (want_on)
        begin
          // fault picks latch or retry; warnings ignored
          if (fault_ov) n.cause = rfs_pkg::CAUSE_OV;
          else if (fault_ot) n.cause = rfs_pkg::CAUSE_OT;
          else if (fault_prim) n.cause = rfs_pkg::CAUSE_PRIM;
          else n.cause = rfs_pkg::CAUSE_OC;
          // overload ignored during start hold; hiccup below 7V
          if (fault_ov || fault_ot || fault_prim || (oc_cond &&
              (r.st == rfs_pkg::S_ON || r.tmr >= ms(rfs_pkg::CC_HOLD_MS))))
          begin
            n.tmr = '0;
            n.off_tmr = '0;
            n.st = rfs_pkg::S_RETRY;
            if (cfg[n.cause])
              n.st = rfs_pkg::S_LATCH;
            if (fault_ov)
            begin
              n.win_act = 1'b1;
              if (!r.win_act)
              begin
                n.win_tmr = '0;
                n.tries = 2'h0;
              end
              // latch on the fault that ends the last attempt
              else if (r.tries == 2'(rfs_pkg::OV_MAX_TRIES - 1))
                n.st = rfs_pkg::S_LATCH;
              else
                n.tries = r.tries + 2'h1;
            end
            if (n.st == rfs_pkg::S_LATCH)
              n.frozen = 1'b1;
          end
        end
      end
      rfs_pkg::S_RETRY:
      begin
        if (!want_on)
          n.st = rfs_pkg::S_OFF;
        else if (r.tmr >= ms(rfs_pkg::RETRY_MS))
        begin
          n.st = rfs_pkg::S_START;
          n.tmr = '0;
          n.rs_pend = 1'b1;
        end
      end
      rfs_pkg::S_LATCH:
      begin
        // 2 s off cycle or mode change
        if ((want_on && r.off_tmr >= ms(rfs_pkg::MIN_OFF_MS)) ||
            !cfg[r.cause])
        begin
          n.st = rfs_pkg::S_START;
          n.tmr = '0;
          n.rs_pend = 1'b1;
        end
      end
      default: n.st = rfs_pkg::S_OFF;
    endcase

    // -------------------------------------------------------------
    // status, alarm capture and alert
    // -------------------------------------------------------------
    al_live = {in_limit, fault_prim, fault_ot, warn_in[rfs_pkg::AL_OTW],
               oc_cond, fault_ov, warn_in[rfs_pkg::AL_VOUT], vin_bad};
    inf_live = info_in;
    inf_live[rfs_pkg::INF_ORING] = oring_fail;
    inf_live[rfs_pkg::INF_FAN] = fan_warn;
    if (r.frozen && !clr)
    begin
      n.alarm = n.alarm | al_live;
      n.info = n.info | inf_live;
    end
    else
    begin
      n.alarm = al_live;
      n.info = inf_live;
      // a set in this cycle outlives the clear
      if (clr)
      begin
        n.frozen = n.frozen & ~r.frozen;
        n.status2[rfs_pkg::S2_RESTART_OK] =
          n.status2[rfs_pkg::S2_RESTART_OK] &
          ~r.status2[rfs_pkg::S2_RESTART_OK];
      end
    end
    n.status = {n.st == rfs_pkg::S_ON, n.st == rfs_pkg::S_LATCH,
                n.st == rfs_pkg::S_RETRY, n.st == rfs_pkg::S_START,
                in_limit, vin_bad, |(n.alarm & rfs_pkg::AL_INTERNAL),
                n.frozen};
    n.status2[rfs_pkg::S2_FAN_WARN] = fan_warn;
    n.status2[rfs_pkg::S2_SETTLED] = n.settled;
    if (n.status != r.status || n.status2 != r.status2)
      n.alert_pend = 1'b1;
    if (r.alert_pend)
      n.str_tmr = '0;
    if (clr)
      n.alert_pend = n.alert_pend & (n.status != r.status ||
                                     n.status2 != r.status2);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.st <= rfs_pkg::S_OFF;
      r.test <= rfs_pkg::TEST_RESET;
      r.op_on <= 1'b1;
      r.str_tmr <= ms(rfs_pkg::STRETCH_MS);
      r.alert_pend <= 1'b1;
    end
    else if (ce)
      r <= n;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.ack   = r.ack;
  assign link.miss  = r.miss;
  assign link.rdata = r.rdata;
  assign link.alert = r.alert_pend | (r.test[rfs_pkg::TEST_STRETCH] &
                      (r.str_tmr < ms(rfs_pkg::STRETCH_MS)));
  assign power_en   = (r.st == rfs_pkg::S_START) | (r.st == rfs_pkg::S_ON);
  assign cc_hold    = (r.st == rfs_pkg::S_START);
  assign hiccup     = (r.st == rfs_pkg::S_RETRY);
  assign oring_run  = r.test[rfs_pkg::TEST_ORING];
  // outside LED test, blink in limit above 7V; lit only when on
  assign led_out = r.test[rfs_pkg::TEST_LED] ? lit :
                   (r.st == rfs_pkg::S_ON) &
                   (~(in_limit & vout_above_7v) | r.blink);
  // outside LED test, input LED blinks on bad input, dark without input
  assign led_in = r.test[rfs_pkg::TEST_LED] ? lit :
                  vin_present & (~vin_bad | r.blink);
  assign fault_pin = |(r.alarm & rfs_pkg::AL_INTERNAL);
  assign led_fault = r.test[rfs_pkg::TEST_LED] ? lit : fault_pin;
  assign led_aux   = r.test[rfs_pkg::TEST_LED] ? lit : vin_present;
endmodule // rfs_dev
`default_nettype wire

// *** logic/rfs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfs_host #(
  parameter int MS_CYC = rfs_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // link to device
  rfs_link_if.host         link
);
  localparam int W = rfs_pkg::MSW;

  typedef struct packed {
    logic [31:0]  div;
    logic         req;
    logic         wr;
    logic [2:0]   sel;
    logic [7:0]   addr;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic         miss;
    logic         en;
    logic         en_req;
    logic [W-1:0] off_tmr;
    logic [W-1:0] hold;
    logic [31:0]  prdata;
    logic         perr;
  } rfs_host_t;

  rfs_host_t r;
  rfs_host_t n;
  logic      tick;
  logic      acc;

  assign tick = (r.div == 32'(MS_CYC - 1));
  assign acc  = psel & penable;

  always_comb
  begin
    n = r;
    n.div = tick ? 32'h0 : r.div + 32'h1;
    if (tick && r.hold != '0)
      n.hold = r.hold - 1'b1;
    if (!r.en && tick && r.off_tmr != '1)
      n.off_tmr = r.off_tmr + 1'b1;
    // keep off at least the minimum; sync off time
    if (!r.en_req)
    begin
      if (r.en) n.off_tmr = '0;
      n.en = 1'b0;
    end
    else if (r.off_tmr >= rfs_pkg::SYNC_OFF_MS[W-1:0])
      n.en = 1'b1;
    if (r.req && link.ack)
    begin
      n.req = 1'b0;
      n.miss = link.miss;
      n.rdata = link.rdata;
      if (r.wr && r.addr == rfs_pkg::REG_TEST &&
          r.wdata[rfs_pkg::TEST_ORING] && !link.miss)
        n.hold = rfs_pkg::ORING_WAIT_MS[W-1:0];
    end
    if (psel && !penable)
    begin
      n.perr = !(paddr == rfs_pkg::H_CMD || paddr == rfs_pkg::H_STAT ||
                 paddr == rfs_pkg::H_CTRL);
      case (paddr)
        rfs_pkg::H_STAT: n.prdata = {16'h0, r.rdata, 3'h0,
                         r.hold != '0, r.en, link.alert, r.miss, r.req};
        rfs_pkg::H_CTRL: n.prdata = {30'h0, 1'b0, r.en_req};
        default: n.prdata = 32'h0;
      endcase
    end
    if (acc && pwrite)
    begin
      case (paddr)
        rfs_pkg::H_CMD:
        begin
          if (!r.req && r.hold == '0)
          begin
            n.req = 1'b1;
            n.wr = pwdata[rfs_pkg::CMD_WR];
            n.sel = pwdata[rfs_pkg::CMD_SEL_LSB +: 3];
            n.addr = pwdata[rfs_pkg::CMD_ADR_LSB +: 8];
            n.wdata = pwdata[rfs_pkg::CMD_DAT_LSB +: 8];
          end
        end
        rfs_pkg::H_CTRL:
        begin
          n.en_req = pwdata[rfs_pkg::CTRL_EN];
          if (pwdata[rfs_pkg::CTRL_PLUG])
            n.hold = rfs_pkg::ADDR_SETTLE_MS[W-1:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.off_tmr <= rfs_pkg::SYNC_OFF_MS[W-1:0];
    end
    else if (ce)
      r <= n;
  end

  assign pready      = 1'b1;
  assign pslverr     = acc & r.perr;
  assign prdata      = r.prdata;
  assign link.req    = r.req;
  assign link.wr     = r.wr;
  assign link.sel    = r.sel;
  assign link.addr   = r.addr;
  assign link.wdata  = r.wdata;
  assign link.enable = r.en;
endmodule // rfs_host
`default_nettype wire

// *** logic/rfs_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface rfs_link_if;
  logic       req;
  logic       wr;
  logic [2:0] sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       enable;
  logic       ack;
  logic       miss;
  logic [7:0] rdata;
  logic       alert;

  modport dev (
    input  req, wr, sel, addr, wdata, enable,
    output ack, miss, rdata, alert
  );
  modport host (
    output req, wr, sel, addr, wdata, enable,
    input  ack, miss, rdata, alert
  );
endinterface
`default_nettype wire

// *** logic/rfs_pkg.sv ***
package rfs_pkg;
  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int MS_NS         = 1000000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam int MSW           = 16;

  // times in milliseconds; retry count and fan percentages
  localparam int STRETCH_MS     = 25;
  localparam int LED_ON_MS      = 7000;
  localparam int LED_OFF_MS     = 2000;
  localparam int BLINK_MS       = 500;
  localparam int CC_HOLD_MS     = 20000;
  localparam int RETRY_MS       = 1000;
  localparam int OV_WIN_MS      = 60000;
  localparam int MIN_OFF_MS     = 2000;
  localparam int ADDR_SETTLE_MS = 15000;
  localparam int ORING_WAIT_MS  = 30000;
  localparam int SYNC_OFF_MS    = 20000;
  localparam int OV_MAX_TRIES   = 3;
  localparam int FAN_PCT        = 20;
  localparam int PCT_FULL       = 100;

  // ---------------------------------------------------------------
  // device registers on the link
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_TEST    = 8'hdf;
  localparam logic [7:0] REG_OP      = 8'h01;
  localparam logic [7:0] REG_CLEAR   = 8'h03;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_STATUS2 = 8'h11;
  localparam logic [7:0] REG_ALARM   = 8'h12;
  localparam logic [7:0] REG_INFO    = 8'h13;
  localparam logic [7:0] TEST_MASK   = 8'h91;
  localparam logic [7:0] TEST_RESET  = 8'h00;
  localparam int TEST_STRETCH = 7;
  localparam int TEST_ORING   = 4;
  localparam int TEST_LED     = 0;
  localparam int OP_ON        = 7;
  localparam logic [2:0] ADDR_DEFAULT = 3'h0;

  // alarm byte
  localparam int AL_PLIM = 7;
  localparam int AL_PRIM = 6;
  localparam int AL_OT   = 5;
  localparam int AL_OTW  = 4;
  localparam int AL_OC   = 3;
  localparam int AL_OV   = 2;
  localparam int AL_VOUT = 1;
  localparam int AL_VIN  = 0;
  localparam logic [7:0] AL_INTERNAL = 8'h44;
  // info byte overlays
  localparam int INF_ORING = 3;
  localparam int INF_FAN   = 4;
  // status2 byte
  localparam int S2_RESTART_OK = 0;
  localparam int S2_FAN_WARN   = 1;
  localparam int S2_SETTLED    = 2;

  // fault cause index into latch configuration
  localparam logic [1:0] CAUSE_OV   = 2'h0;
  localparam logic [1:0] CAUSE_OT   = 2'h1;
  localparam logic [1:0] CAUSE_OC   = 2'h2;
  localparam logic [1:0] CAUSE_PRIM = 2'h3;

  typedef enum logic [2:0] {
    S_OFF, S_START, S_ON, S_RETRY, S_LATCH
  } rfs_dev_st_t;

  // ---------------------------------------------------------------
  // host apb registers
  // ---------------------------------------------------------------
  localparam logic [7:0] H_CMD  = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam logic [7:0] H_CTRL = 8'h08;
  localparam int CTRL_EN     = 0;
  localparam int CTRL_PLUG   = 1;
  localparam int CMD_WR      = 0;
  localparam int CMD_SEL_LSB = 1;
  localparam int CMD_ADR_LSB = 8;
  localparam int CMD_DAT_LSB = 16;
endpackage

// *** tb/rectifier_fault_restart_supervisor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rectifier_fault_restart_supervisor_tb;
  // ----------------------------
  // bench signals
  // ----------------------------
  localparam int MSC = 2;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, info_in, warn_in;
  logic [31:0] pwdata, prdata, rd;
  logic        present, vin_present, vin_bad, pgood, fault_ov, fault_ot;
  logic        fault_prim, in_limit, vout_above_7v, oring_fail, nv_latch;
  logic [2:0]  addr_strap, latch_cfg;
  logic [15:0] fan_rpm [2];
  logic        power_en, cc_hold, oring_run, hiccup, fault_pin, err;
  logic        led_out, led_in, led_fault, led_aux;
  int          failures = 0, check_count = 0, cyc = 0;

  rfs_link_if lnk ();
  rfs_host #(.MS_CYC(MSC)) rfs_host_inst (.*, .link(lnk));
  rfs_dev #(.MS_CYC(MSC), .NFAN(2)) rfs_dev_inst (.*, .link(lnk));
  rfs_link_properties #(.MS_CYC(MSC)) rfs_link_properties_inst (
    .pclk, .presetn, .req(lnk.req), .wr(lnk.wr), .sel(lnk.sel),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .miss(lnk.miss),
    .rdata(lnk.rdata), .alert(lnk.alert));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 99000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // device access through the host, status left in rd
  task automatic dcmd(input logic w, input logic [2:0] s,
    input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, rfs_pkg::H_CMD, {8'h00, d, a, 4'h0, s, w});
    repeat (2) @(posedge pclk);
    do apb(1'b0, rfs_pkg::H_STAT, '0); while (rd[0] !== 1'b0);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {vin_bad, fault_ov, fault_ot, fault_prim, in_limit, oring_fail} = '0;
    {ce, present, vin_present, pgood, vout_above_7v, nv_latch} = 6'h3e;
    {info_in, warn_in, latch_cfg} = '0;
    addr_strap = 3'h5;
    fan_rpm = '{16'h0bb8, 16'h0bb8};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, rfs_pkg::H_STAT, '0);
    chk(rd[2], 1'b1);
    apb(1'b0, 8'h0c, '0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    dcmd(1'b0, 3'h5, rfs_pkg::REG_STATUS, 8'h00);
    chk(rd[1], 1'b1);
    $display("test access done");
    dcmd(1'b1, 3'h0, rfs_pkg::REG_TEST, 8'hff);
    chk(rd[4], 1'b1);
    chk(oring_run, 1'b1);
    chk({led_out, led_in, led_fault, led_aux}, 4'hf);
    repeat (7200 * MSC) @(posedge pclk);
    chk({led_out, led_in, led_fault, led_aux}, 4'h0);
    repeat (2000 * MSC) @(posedge pclk);
    chk({led_out, led_in, led_fault, led_aux}, 4'hf);
    // isolation wait blocks commands; address settles to strap meanwhile
    do apb(1'b0, rfs_pkg::H_STAT, '0); while (rd[4] !== 1'b0);
    dcmd(1'b0, 3'h5, rfs_pkg::REG_TEST, 8'h00);
    chk(rd[15:8], rfs_pkg::TEST_MASK);
    dcmd(1'b1, 3'h5, rfs_pkg::REG_TEST, 8'h00);
    chk(oring_run, 1'b0);
    $display("test control byte done");
    apb(1'b1, rfs_pkg::H_CTRL, 32'h1);
    while (power_en !== 1'b1) @(posedge pclk);
    chk(cc_hold, 1'b1);
    repeat (100 * MSC) @(posedge pclk);
    chk({led_out, cc_hold}, 2'b10);
    dcmd(1'b0, 3'h5, rfs_pkg::REG_STATUS, 8'h00);
    in_limit <= 1'b1;
    warn_in  <= 8'h12;
    info_in  <= 8'h08;
    repeat (10 * MSC) @(posedge pclk);
    chk(lnk.alert, 1'b1);
    chk({power_en, fault_pin, led_fault}, 3'b100);
    $display("test power on done");
    in_limit  <= 1'b0;
    fault_ot  <= 1'b1;
    repeat (10 * MSC) @(posedge pclk);
    chk({power_en, hiccup}, 2'b01);
    fault_ot  <= 1'b0;
    repeat (1100 * MSC) @(posedge pclk);
    chk({power_en, hiccup}, 2'b10);
    dcmd(1'b0, 3'h5, rfs_pkg::REG_STATUS2, 8'h00);
    chk(rd[8 + rfs_pkg::S2_RESTART_OK], 1'b1);
    latch_cfg <= 3'b001;
    fault_ov  <= 1'b1;
    repeat (10 * MSC) @(posedge pclk);
    fault_ov  <= 1'b0;
    repeat (2000 * MSC) @(posedge pclk);
    chk({power_en, led_out, fault_pin}, 3'b001);
    dcmd(1'b0, 3'h5, rfs_pkg::REG_ALARM, 8'h00);
    chk(rd[8 + rfs_pkg::AL_OV], 1'b1);
    $display("test latch off done");
    wrap_up();
  end
endmodule // rectifier_fault_restart_supervisor_tb
`default_nettype wire

// *** tb/rfs_link_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module rfs_link_properties #(
  parameter int MS_CYC = 2
) (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link
  input wire logic       req,
  input wire logic       wr,
  input wire logic [2:0] sel,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic       miss,
  input wire logic [7:0] rdata,
  input wire logic       alert
);
  // ----------------------------
  // link handshake and answers
  // ----------------------------
  localparam int LIM = 14000 * MS_CYC;
  int age;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // cycles since reset, address cannot be settled before LIM
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      age <= 0;
    else if (age < LIM)
      age <= age + 1;

  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_timely: assert property ($rose(req) |=> ack)
    else $error("ack not one cycle after request");
  a_req_release: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_req_held: assert property (
    req && !ack |=> req && $stable({wr, sel, addr, wdata}))
    else $error("request changed before ack");
  a_miss_qual: assert property (miss |-> ack)
    else $error("miss without ack");
  a_default_addr: assert property (
    ack && age < LIM |-> miss == (sel != rfs_pkg::ADDR_DEFAULT))
    else $error("unsettled address not default");
  a_test_reserved: assert property (
    ack && !miss && !wr && addr == rfs_pkg::REG_TEST |->
    (rdata & ~rfs_pkg::TEST_MASK) == 8'h00)
    else $error("reserved test bits read nonzero");
  a_powerup_alert: assert property (!$past(presetn) |-> alert)
    else $error("no alert after power-up");
endmodule // rfs_link_properties
`default_nettype wire
